// ==== core/pwmo_map.vh ====
// Purpose: register indices, field positions, reset values and timing constants of the pwm output stage
// Assumes: every printed offset is a register index; the byte address is four times the index
// Notes:   definitions only
`ifndef PWMO_MAP_VH
`define PWMO_MAP_VH

// register indices, compared against wb_adr_i[31:2]
`define PWMO_IDX_W              30
`define PWMO_IDX_EN0            30'h0FFFF57F
`define PWMO_IDX_SW0            30'h0FFFF57E
`define PWMO_IDX_EN1            30'h0FFFF5BF
`define PWMO_IDX_SW1            30'h0FFFF5BE
`define PWMO_IDX_STAT           30'h0FFFF57D

// reset values
`define PWMO_EN_RESET           6'h00
`define PWMO_SEL_RESET          1'h0
`define PWMO_PH_RESET           3'h0
`define PWMO_OE_N_RESET         6'h3F
`define PWMO_PIN_RESET          2'h0

// field positions inside the byte
`define PWMO_SW_SEL_BIT         7
`define PWMO_PH_A_BIT           2
`define PWMO_EN_MSB             5
`define PWMO_PH_MSB             2

// pwm modes on pwm_mode, two bits per group
`define PWMO_MODE_TRI0          2'h0
`define PWMO_MODE_TRI1          2'h1
`define PWMO_MODE_SAW           2'h2

// timing
`define PWMO_CLK_PERIOD_NS      50
`define PWMO_DEAD_TIME_NS       1000

// pad constants for the read mux
`define PWMO_PAD_EN             26'h0000000
`define PWMO_PAD_SW             24'h000000
`define PWMO_PAD_SW_MID         4'h0
`define PWMO_PAD_STAT           20'h00000
`define PWMO_ZERO32             32'h00000000

`endif

// ==== core/pwmo_top.v ====
// Purpose: output stage of two six-pin motor pwm groups: pin enables, software output, output flip-flops
// Assumes: counter, compares, pwm mode and polarity settings come from the timer as same-clock inputs;
//          emergency stop arrives from a pin and is synchronised here
// Notes:   classic wishbone slave, ack one cycle after the request is seen, write takes effect at the ack edge
// Operation
// - pin-enable registers accept byte writes and single-bit changes via byte read-modify-write.
// - six enable bits, bit k governs pin k of its group.
// - enable bit zero floats the pin regardless of anything else.
// - enable bit one drives the pin per counter run, software select, emergency stop.
// - software-output registers of both groups accept byte and single-bit accesses.
// - switching to software while timer drives: a differing level waits the dead time.
// - switching to software with equal level: pin holds level, no glitch, no delay.
// - period and compare-three interrupts keep firing while software output is selected.
// - in software output with counter running, phase bits win over timer levels.
// - leaving software output while counting: pins hold until the next set/reset event.
// - triangular modes: compare match counting up sets, counting down resets.
// - sawtooth mode: match with compare three sets, own compare match resets.
// - in software output, writing one to a phase bit sets, zero resets.
// - rewriting a phase bit unchanged leaves its pin pair alone; a:0/1, b:2/3, c:4/5.
// - bit seven of software-output register: zero timer output, one software output.
// - phase a at bit two; pin 0 active level when one; pin 1 per polarity.
`include "pwmo_map.vh"

module pwmo_top #(
  parameter DEAD_CNT_W = 8
) (
  input  wire        clk,             // 20 MHz system clock
  input  wire        reset,           // synchronous, active high
  input  wire        wb_cyc_i,        // wishbone cycle
  input  wire        wb_stb_i,        // wishbone strobe
  input  wire        wb_we_i,         // wishbone write
  input  wire [31:0] wb_adr_i,        // wishbone byte address
  input  wire [3:0]  wb_sel_i,        // wishbone byte enables
  input  wire [31:0] wb_dat_i,        // wishbone write data
  output wire [31:0] wb_dat_o,        // wishbone read data
  output wire        wb_ack_o,        // wishbone acknowledge
  input  wire [1:0]  counter_run,     // per group counter running
  input  wire [1:0]  count_up,        // per group counter direction, 1 = up
  input  wire [3:0]  pwm_mode,        // per group pwm mode, 2 bits each
  input  wire [5:0]  compare_match,   // per group phase a/b/c compare match pulses
  input  wire [1:0]  compare3_match,  // per group counter equals compare three
  input  wire [1:0]  period_event,    // per group timer period event
  input  wire [1:0]  active_level_setting,  // per group active level
  input  wire [5:0]  phase_polarity,  // per group pair polarity for phases a/b/c
  input  wire [1:0]  emergency_stop_in,     // per group stop pin, asynchronous
  output wire [11:0] pwm_pin_o,       // pin output levels, group 1 in bits 11:6
  output wire [11:0] pwm_pin_oe_n,    // pin output enables, low while driven
  output wire [1:0]  period_irq,      // per group period interrupt pulse
  output wire [1:0]  compare3_irq     // per group compare three interrupt pulse
);

  reg         ack_reg;
  reg  [31:0] dat_reg;
  reg  [31:0] dat_next;
  wire [`PWMO_IDX_W-1:0] idx = wb_adr_i[31:2];
  wire        req    = wb_cyc_i & wb_stb_i;
  // a write lands on the edge where the master samples ack, so it happens exactly once
  wire        wr_now = req & wb_we_i & ack_reg & wb_sel_i[0];

  wire [11:0] en_bus;
  wire [1:0]  sel_bus;
  wire [5:0]  ph_bus;

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;

  // read mux; unmapped indices answer with zero and ignore writes
  always @* begin
    if (idx == `PWMO_IDX_EN0) begin
      dat_next = {`PWMO_PAD_EN, en_bus[5:0]};
    end else if (idx == `PWMO_IDX_EN1) begin
      dat_next = {`PWMO_PAD_EN, en_bus[11:6]};
    end else if (idx == `PWMO_IDX_SW0) begin
      dat_next = {`PWMO_PAD_SW, sel_bus[0], `PWMO_PAD_SW_MID, ph_bus[2:0]};
    end else if (idx == `PWMO_IDX_SW1) begin
      dat_next = {`PWMO_PAD_SW, sel_bus[1], `PWMO_PAD_SW_MID, ph_bus[5:3]};
    end else if (idx == `PWMO_IDX_STAT) begin
      dat_next = {`PWMO_PAD_STAT, pwm_pin_o};
    end else begin
      dat_next = `PWMO_ZERO32;
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      ack_reg <= 1'b0;
      dat_reg <= `PWMO_ZERO32;
    end else begin
      ack_reg <= req & ~ack_reg;
      if (req & ~ack_reg) begin
        dat_reg <= dat_next;
      end
    end
  end

  genvar g;
  genvar p;
  generate
    for (g = 0; g < 2; g = g + 1) begin : grp
      localparam [`PWMO_IDX_W-1:0] EN_IDX = (g == 0) ? `PWMO_IDX_EN0 : `PWMO_IDX_EN1;
      localparam [`PWMO_IDX_W-1:0] SW_IDX = (g == 0) ? `PWMO_IDX_SW0 : `PWMO_IDX_SW1;

      reg  [5:0] en_reg;
      reg        sel_reg;
      reg  [2:0] ph_reg;
      wire       stop_sync;
      reg        per_irq_reg;
      reg        cmp3_irq_reg;
      reg  [5:0] oe_n_reg;

      wire       run    = counter_run[g];
      wire [1:0] mode   = pwm_mode[2*g+1:2*g];
      wire       al     = active_level_setting[g];
      wire       wr_en  = wr_now & (idx == EN_IDX);
      wire       wr_sw  = wr_now & (idx == SW_IDX);
      wire       sel_nx = wb_dat_i[`PWMO_SW_SEL_BIT];
      // software source when selected; timer source only while the counter runs
      wire       drive  = (sel_reg | run) & ~stop_sync;

      assign en_bus[6*g+5:6*g] = en_reg;
      assign sel_bus[g]        = sel_reg;
      assign ph_bus[3*g+2:3*g] = ph_reg;
      assign pwm_pin_oe_n[6*g+5:6*g] = oe_n_reg;
      assign period_irq[g]     = per_irq_reg;
      assign compare3_irq[g]   = cmp3_irq_reg;

      pwmo_sync3 u_stop_sync (
        .clk      (clk),
        .reset    (reset),
        .async_in (emergency_stop_in[g]),
        .sync_out (stop_sync)
      );

      always @(posedge clk) begin
        if (reset) begin
          en_reg       <= `PWMO_EN_RESET;
          sel_reg      <= `PWMO_SEL_RESET;
          ph_reg       <= `PWMO_PH_RESET;
          per_irq_reg  <= 1'b0;
          cmp3_irq_reg <= 1'b0;
          oe_n_reg     <= `PWMO_OE_N_RESET;
        end else begin
          if (wr_en) begin
            en_reg <= wb_dat_i[`PWMO_EN_MSB:0];
          end
          if (wr_sw) begin
            sel_reg <= sel_nx;
            ph_reg  <= wb_dat_i[`PWMO_PH_MSB:0];
          end
          // interrupts follow the timer whatever the pin source
          per_irq_reg  <= period_event[g];
          cmp3_irq_reg <= compare3_match[g];
          oe_n_reg     <= ~en_reg;
        end
      end

      for (p = 0; p < 3; p = p + 1) begin : ph
        pwmo_phase #(
          .DEAD_CNT_W (DEAD_CNT_W),
          .BIT        (`PWMO_PH_A_BIT - p)
        ) u_phase (
          .clk     (clk),
          .reset   (reset),
          .sw_load (wr_sw & sel_nx),
          .sw_byte (wb_dat_i[7:0]),
          .sel     (sel_reg),
          .run     (run),
          .up      (count_up[g]),
          .mode    (mode),
          .cm      (compare_match[3*g+p]),
          .cm3     (compare3_match[g]),
          .al      (al),
          .pol     (phase_polarity[3*g+p]),
          .drive   (drive),
          .pin     (pwm_pin_o[6*g+2*p+1:6*g+2*p])
        );
      end
    end
  endgenerate

endmodule

// one phase: output flip-flop, dead-time delay and the pin pair it drives
module pwmo_phase #(
  parameter DEAD_CNT_W = 8,  // dead-time counter width
  parameter BIT        = 2   // phase bit inside the software-output byte
) (
  input  wire       clk,     // system clock
  input  wire       reset,   // synchronous, active high
  input  wire       sw_load, // software write with select set, this cycle
  input  wire [7:0] sw_byte, // byte being written
  input  wire       sel,     // software output selected
  input  wire       run,     // counter running
  input  wire       up,      // counter direction, 1 = up
  input  wire [1:0] mode,    // pwm mode of the group
  input  wire       cm,      // own compare match
  input  wire       cm3,     // counter equals compare three
  input  wire       al,      // active level
  input  wire       pol,     // pair polarity
  input  wire       drive,   // pins follow the level, else inactive
  output wire [1:0] pin      // odd pin in bit 1, even pin in bit 0
);

  localparam DEAD_CYCLES_RAW = (`PWMO_DEAD_TIME_NS + `PWMO_CLK_PERIOD_NS - 1) / `PWMO_CLK_PERIOD_NS;
  localparam DEAD_CYCLES     = (DEAD_CYCLES_RAW < 1) ? 1 : DEAD_CYCLES_RAW;
  localparam [31:0] DEAD_LAST_W = DEAD_CYCLES - 1;
  localparam [DEAD_CNT_W-1:0] DEAD_LAST = DEAD_LAST_W[DEAD_CNT_W-1:0];
  localparam [DEAD_CNT_W-1:0] DEAD_ZERO = {DEAD_CNT_W{1'b0}};
  localparam [DEAD_CNT_W-1:0] DEAD_ONE  = {{(DEAD_CNT_W-1){1'b0}}, 1'b1};

  reg                  ff_reg;
  reg                  ff_next;
  reg                  lvl_reg;
  reg [DEAD_CNT_W-1:0] dcnt_reg;
  reg [1:0]            pin_reg;

  wire lvl0 = lvl_reg ? al : ~al;
  wire lvl1 = pol ? lvl0 : ~lvl0;

  assign pin = pin_reg;

  // output flip-flop set/reset conditions
  always @* begin
    ff_next = ff_reg;
    if (sw_load) begin
      ff_next = sw_byte[BIT];
    end else if (~sel & run) begin
      // timer events are ignored while software output is selected
      if (mode == `PWMO_MODE_SAW) begin
        if (cm3) begin
          ff_next = 1'b1;
        end else if (cm) begin
          ff_next = 1'b0;
        end
      end else if ((mode == `PWMO_MODE_TRI0) | (mode == `PWMO_MODE_TRI1)) begin
        if (cm) begin
          ff_next = up;
        end
      end
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      ff_reg   <= 1'b0;
      lvl_reg  <= 1'b0;
      dcnt_reg <= DEAD_ZERO;
      pin_reg  <= `PWMO_PIN_RESET;
    end else begin
      // ff only moves on its own events, so a deselect holds the software level
      ff_reg <= ff_next;
      if (ff_reg == lvl_reg) begin
        dcnt_reg <= DEAD_ZERO;
      end else if (~run | (dcnt_reg == DEAD_LAST)) begin
        lvl_reg  <= ff_reg;
        dcnt_reg <= DEAD_ZERO;
      end else begin
        // a level change while the timer runs waits out the dead time
        dcnt_reg <= dcnt_reg + DEAD_ONE;
      end
      if (drive) begin
        pin_reg <= {lvl1, lvl0};
      end else begin
        pin_reg <= {~al, ~al};
      end
    end
  end

endmodule

// three-stage synchroniser for an asynchronous pin
module pwmo_sync3 (
  input  wire clk,      // system clock
  input  wire reset,    // synchronous, active high
  input  wire async_in, // level from a pin
  output wire sync_out  // filtered level, same clock
);

  reg s1_reg;
  reg s2_reg;
  reg s3_reg;
  reg out_reg;

  assign sync_out = out_reg;

  // the first stage may be metastable, so only the second and third feed the compare
  always @(posedge clk) begin
    if (reset) begin
      s1_reg  <= 1'b0;
      s2_reg  <= 1'b0;
      s3_reg  <= 1'b0;
      out_reg <= 1'b0;
    end else begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        out_reg <= s3_reg;
      end
    end
  end

endmodule

// ==== tb/pwmo_assertions.sv ====
// Purpose: port-level checks of the pwm output stage
// Assumes: one clock, synchronous active-high reset
// Notes:   bound to the top module at the foot of this file
module pwmo_checker (
  input logic        clk,                  // clock
  input logic        reset,                // reset
  input logic        wb_cyc_i,             // cycle
  input logic        wb_stb_i,             // strobe
  input logic [31:0] wb_dat_o,             // read data
  input logic        wb_ack_o,             // acknowledge
  input logic [1:0]  period_event,         // period pulses
  input logic [1:0]  compare3_match,       // compare three pulses
  input logic [1:0]  active_level_setting, // active level
  input logic [1:0]  emergency_stop_in,    // stop pins
  input logic [11:0] pwm_pin_o,            // pin levels
  input logic [11:0] pwm_pin_oe_n,         // pin enables
  input logic [1:0]  period_irq,           // period irq
  input logic [1:0]  compare3_irq          // compare three irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_answers: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered");
  a_ack_needs_req: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  a_dat_holds: assert property (!(wb_cyc_i && wb_stb_i) |=> $stable(wb_dat_o))
    else $error("read data moved while idle");
  a_period_irq: assert property (1'b1 |=> period_irq == $past(period_event))
    else $error("period irq lost");
  a_cmp3_irq: assert property (1'b1 |=> compare3_irq == $past(compare3_match))
    else $error("compare three irq lost");
  a_reset_float: assert property ($past(reset) |-> pwm_pin_oe_n == 12'hFFF && pwm_pin_o == 12'h000)
    else $error("pins not floated after reset");
  a_stop_inactive: assert property ((emergency_stop_in[0] && $stable(active_level_setting[0])) [*7]
    |-> pwm_pin_o[5:0] == {6{~active_level_setting[0]}})
    else $error("stop did not force inactive level");
endmodule

bind pwmo_top pwmo_checker u_chk (.*);

// ==== tb/testbench.sv ====
// Purpose: self-checking bench of the pwm output stage
// Assumes: ack one cycle after a request, dead time of 20 cycles while counting
// Notes:   expected pin levels come from a small model of the pin pair rules
`include "pwmo_map.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 0, reset = 1, cyc = 0, we = 0, ack;
  logic [31:0] adr = 0, wd = 0, rd, q;
  logic [3:0]  sel = 0, mode = 0;
  logic [1:0]  run = 0, up = 0, c3 = 0, per = 0, al = 2'h3, stop = 0, pirq, cirq;
  logic [5:0]  cm = 0, pol = 0;
  logic [11:0] pin, oen;
  logic [7:0]  d;
  logic [2:0]  ph [0:1];
  logic [29:0] ei [0:1], si [0:1];
  integer      n_errors = 0, check_count = 0, seed = 32'h1482, g, m;
  pwmo_top dut (.clk(clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(q), .wb_ack_o(ack), .counter_run(run), .count_up(up),
    .pwm_mode(mode), .compare_match(cm), .compare3_match(c3), .period_event(per),
    .active_level_setting(al), .phase_polarity(pol), .emergency_stop_in(stop), .pwm_pin_o(pin),
    .pwm_pin_oe_n(oen), .period_irq(pirq), .compare3_irq(cirq));
  always #25 clk = ~clk;
  // random period events keep the irq path busy in every mode
  always @(posedge clk) per <= 2'($random(seed));
  task chk(input [31:0] got, input [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wb(input w, input [29:0] idx, input [7:0] dv);
    @(posedge clk);
    cyc <= 1;
    we <= w;
    adr <= {idx, 2'h0};
    wd <= {24'h0, dv};
    sel <= 4'h1;
    // no cycle count is assumed; only the watchdog ends a wait
    while (ack !== 1'b1)
      @(posedge clk);
    rd = q;
    cyc <= 0;
    @(posedge clk);
  endtask
  task pulse(input [5:0] mv, input [1:0] cv);
    @(posedge clk);
    cm <= mv;
    c3 <= cv;
    @(posedge clk);
    cm <= 0;
    c3 <= 0;
    repeat (25) @(posedge clk);
  endtask
  function automatic [5:0] pexp(input [2:0] p, input a, input [2:0] pp);
    for (int j = 0; j < 3; j++) begin
      pexp[2*j] = p[2-j] ? a : ~a;
      pexp[2*j+1] = pp[j] ? pexp[2*j] : ~pexp[2*j];
    end
  endfunction
  task end_of_test;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #2000000;
    n_errors++;
    end_of_test;
  end
  initial begin
    ei[0] = `PWMO_IDX_EN0;
    ei[1] = `PWMO_IDX_EN1;
    si[0] = `PWMO_IDX_SW0;
    si[1] = `PWMO_IDX_SW1;
    repeat (4) @(posedge clk);
    reset <= 0;
    pol <= 6'($random(seed));
    al <= 2'($random(seed));
    chk(oen, 12'hFFF);
    for (g = 0; g < 2; g++) begin
      wb(0, si[g], 8'h00);
      chk(rd, 0);
      d = 8'($random(seed));
      wb(1, ei[g], d);
      wb(0, ei[g], 8'h00);
      chk(rd, {24'h0, d & 8'h3F});
      wb(1, ei[g], rd[7:0] ^ 8'h08);
      repeat (2) @(posedge clk);
      chk(oen[6*g +: 6], 6'(~(d[5:0] ^ 6'h08)));
    end
    wb(1, `PWMO_IDX_EN0 + 30'h10, 8'hFF);
    wb(0, `PWMO_IDX_EN0 + 30'h10, 8'h00);
    chk(rd, 0);
    $display("test registers done");
    for (g = 0; g < 2; g++) begin
      ph[g] = 3'($random(seed));
      wb(1, ei[g], 8'h3F);
      wb(1, si[g], 8'h80 | ph[g]);
      repeat (4) @(posedge clk);
      chk(pin[6*g +: 6], pexp(ph[g], al[g], pol[3*g +: 3]));
      wb(0, si[g], 8'h00);
      chk(rd, {24'h0, 8'h80 | ph[g]});
    end
    $display("test software output done");
    run <= 2'h3;
    wb(1, si[0], 8'h80 | ph[0]);
    pulse(6'h3F, 2'h1);
    chk(pin[5:0], pexp(ph[0], al[0], pol[2:0]));
    wb(1, si[0], 8'h80 | (ph[0] ^ 3'h1));
    repeat (10) @(posedge clk);
    chk(pin[5:0], pexp(ph[0], al[0], pol[2:0]));
    repeat (15) @(posedge clk);
    chk(pin[5:0], pexp(ph[0] ^ 3'h1, al[0], pol[2:0]));
    wb(1, si[0], 8'h00);
    repeat (25) @(posedge clk);
    chk(pin[5:0], pexp(ph[0] ^ 3'h1, al[0], pol[2:0]));
    $display("test dead time done");
    for (m = 0; m < 2; m++) begin
      mode <= 4'(m);
      up <= 2'h1;
      pulse(6'h07, 2'h0);
      chk(pin[5:0], pexp(3'h7, al[0], pol[2:0]));
      up <= 2'h0;
      pulse(6'h01, 2'h0);
      chk(pin[5:0], pexp(3'h3, al[0], pol[2:0]));
    end
    mode <= 4'h2;
    pulse(6'h00, 2'h1);
    chk(pin[5:0], pexp(3'h7, al[0], pol[2:0]));
    pulse(6'h02, 2'h0);
    chk(pin[5:0], pexp(3'h5, al[0], pol[2:0]));
    $display("test flip-flop done");
    stop <= 2'h1;
    repeat (10) @(posedge clk);
    chk(pin[5:0], {6{~al[0]}});
    stop <= 2'h0;
    repeat (10) @(posedge clk);
    chk(pin[5:0], pexp(3'h5, al[0], pol[2:0]));
    $display("test stop done");
    wb(0, `PWMO_IDX_STAT, 8'h00);
    chk(rd, {20'h0, pexp(ph[1], al[1], pol[5:3]), pexp(3'h5, al[0], pol[2:0])});
    // switching into software output while counting, every phase level differs
    wb(1, si[0], 8'h82);
    repeat (10) @(posedge clk);
    chk(pin[5:0], pexp(3'h5, al[0], pol[2:0]));
    repeat (15) @(posedge clk);
    chk(pin[5:0], pexp(3'h2, al[0], pol[2:0]));
    $display("test status and switch-in done");
    end_of_test;
  end
endmodule
